// *** rtl/host_port_cfg_access.sv ***
// Summary of operation
// - Drive wait/acknowledge only once chip select active
// - Initial wait level reflects earlier pending write
// - Posted write: wait active at strobe release
// - Posted 16-bit write captures all sixteen lines
// - Non-posted write starts with wait inactive
// - Non-posted write: wait active at strobe
// - Non-posted write commits at strobe release
// - Read: wait active when read strobe active
// - Read drives data; valid after wait clears
// - 8-bit mode never drives upper lane
// - Control line polarities set by configuration
// - 16-bit byte order follows endianness bit
// - Optional direction plus transfer_strobe signalling
// - Configuration accesses 16-bit wide, or 8-bit wide when bus16 bit clear
`timescale 1ns/100ps
`include "host_port_params.svh"
module host_port_cfg_access (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // Host control lines
  input  wire logic        cs_i,
  input  wire logic        rd_rw_i,
  input  wire logic        wr_strobe_i,
  input  wire logic [3:0]  addr_i,
  // Host data lines
  input  wire logic [15:0] d_i,
  output logic      [15:0] d_o,
  output logic      [1:0]  d_oe_o,
  // Wait / acknowledge pin
  output logic             wait_ack_o,
  output logic             wait_ack_oe_o,
  // Internal side
  output logic      [31:0] cfg_reg_o,
  output logic             write_pending_o
);
  import host_port_pkg::*;

  localparam logic [3:0] RD_LAT    = 4'(`HP_RD_LAT_CYC);
  localparam logic [3:0] NP_LAT    = 4'(`HP_NP_LAT_CYC);
  localparam logic [3:0] CMT_LAT   = 4'(`HP_CMT_CYC);
  localparam int         PEND_MAX  = `HP_CMT_CYC + 2;
  localparam logic [31:0] CFG_RST  = `HP_CFG_RESET;

  // ----------------------------------------
  // State
  // ----------------------------------------
  cyc_state_type state_ff, nxt_state;
  logic [31:0]   cfg_ff, stage_data_ff;
  logic [3:0]    stage_be_ff, pend_cnt_ff, lat_cnt_ff;
  logic          pend_ff, wait_act_ff, nxt_wait;
  logic          is_read_ff, wr_q_ff, rd_q_ff;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic        cs_act, rd_act, wr_act, sel, in_cycle;
  logic        posted, bus16, big_end, wr_fall, posted_cap;
  logic        np_commit, pend_done, lat_load, busy_done, commit_en;
  logic [15:0] swap_in, rd_word, rdata_map;
  logic [31:0] wdata_map, be_mask, commit_data;
  logic [3:0]  be_map, commit_be;

  strobe_decode strobe_decode_inst (
    .cs_i        (cs_i),
    .rd_rw_i     (rd_rw_i),
    .wr_strobe_i (wr_strobe_i),
    .cs_pol_i    (cfg_ff[`HP_F_CS_POL]),
    .rd_pol_i    (cfg_ff[`HP_F_RD_POL]),
    .wr_pol_i    (cfg_ff[`HP_F_WR_POL]),
    .rw_mode_i   (cfg_ff[`HP_F_RW_MODE]),
    .cs_act_o    (cs_act),
    .rd_act_o    (rd_act),
    .wr_act_o    (wr_act)
  );

  assign posted    = cfg_ff[`HP_F_POSTED];
  assign bus16     = cfg_ff[`HP_F_BUS16];
  assign big_end   = cfg_ff[`HP_F_BIG_END];
  assign sel       = cs_act & (addr_i[3:2] == `HP_CFG_SEL);
  assign in_cycle  = (state_ff != ST_IDLE);
  // Trailing edge is caught even when chip select drops in the same sample
  assign wr_fall   = in_cycle & wr_q_ff & ~wr_act;
  assign posted_cap = wr_fall & posted & ~is_read_ff;
  // data still held by host at release
  assign np_commit = wr_fall & ~posted;
  assign pend_done = pend_ff & (pend_cnt_ff == 4'h0);
  assign lat_load  = (state_ff != ST_BUSY) & (state_ff != ST_DONE) & sel
                     & (rd_act | (wr_act & ~posted));
  assign busy_done = (lat_cnt_ff == 4'h0) & ~pend_ff;

  // ----------------------------------------
  // Lane mapping
  // ----------------------------------------
  // byte swap for big endian
  assign swap_in   = big_end ? {d_i[7:0], d_i[15:8]} : d_i;
  // replicated to every lane; be_map picks the lanes written
  assign wdata_map = bus16 ? {swap_in, swap_in} : {4{d_i[7:0]}};
  // 8-bit mode enables the one lane picked by addr_i[1:0]
  assign be_map    = bus16 ? (addr_i[1] ? 4'hc : 4'h3) : (4'h1 << addr_i[1:0]);
  assign rd_word   = addr_i[1] ? cfg_ff[31:16] : cfg_ff[15:0];
  assign rdata_map = bus16 ? (big_end ? {rd_word[7:0], rd_word[15:8]} : rd_word)
                           : {8'h00, cfg_ff[8*addr_i[1:0] +: 8]};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mask
      assign be_mask[8*gi +: 8] = {8{be_map[gi]}};
    end
  endgenerate

  assign commit_en   = pend_done | np_commit;
  assign commit_data = np_commit ? wdata_map : stage_data_ff;
  assign commit_be   = np_commit ? be_map : stage_be_ff;

  // ----------------------------------------
  // Cycle state machine
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_wait  = pend_ff;
    case (state_ff)
      ST_IDLE, ST_SEL: begin
        if (!sel) begin
          nxt_state = ST_IDLE;
        end else if (rd_act) begin
          nxt_state = ST_BUSY;
          nxt_wait  = 1'b1;
        end else if (wr_act && !posted) begin
          nxt_state = ST_BUSY;
          nxt_wait  = 1'b1;
        end else if (!posted) begin
          // no earlier write can be pending
          nxt_state = ST_SEL;
          nxt_wait  = 1'b0;
        end else begin
          // wait shows the write just posted
          nxt_state = ST_SEL;
          nxt_wait  = pend_ff | posted_cap;
        end
      end
      ST_BUSY: begin
        if (!sel) begin
          nxt_state = ST_IDLE;
        end else if (busy_done) begin
          nxt_state = ST_DONE;
          nxt_wait  = 1'b0;
        end else begin
          nxt_wait  = 1'b1;
        end
      end
      default: begin
        if (!sel) begin
          nxt_state = ST_IDLE;
        end else if (!rd_act && !wr_act) begin
          nxt_state = ST_SEL;
        end
        nxt_wait = pend_ff;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_ff    <= ST_IDLE;
      wait_act_ff <= 1'b0;
      wr_q_ff     <= 1'b0;
      rd_q_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      wait_act_ff <= nxt_wait;
      wr_q_ff     <= wr_act;
      rd_q_ff     <= rd_act;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      lat_cnt_ff <= 4'h0;
      is_read_ff <= 1'b0;
    end else if (lat_load) begin
      lat_cnt_ff <= rd_act ? RD_LAT : NP_LAT;
      is_read_ff <= rd_act;
    end else if (state_ff == ST_BUSY && lat_cnt_ff != 4'h0) begin
      lat_cnt_ff <= lat_cnt_ff - 4'h1;
    end else if (state_ff == ST_IDLE) begin
      is_read_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Posted write staging
  // ----------------------------------------
  // set by capture wins over clear
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pend_ff       <= 1'b0;
      pend_cnt_ff   <= 4'h0;
      stage_data_ff <= 32'h0000_0000;
      stage_be_ff   <= 4'h0;
    end else if (posted_cap) begin
      pend_ff       <= 1'b1;
      pend_cnt_ff   <= CMT_LAT;
      stage_data_ff <= wdata_map;
      stage_be_ff   <= be_map;
    end else if (pend_done) begin
      pend_ff       <= 1'b0;
    end else if (pend_ff) begin
      pend_cnt_ff   <= pend_cnt_ff - 4'h1;
    end
  end

  // each cycle fills its own bytes
  // DWORD built up lane by lane
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cfg
      always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          cfg_ff[8*gi +: 8] <= CFG_RST[8*gi +: 8];
        end else if (commit_en && commit_be[gi]) begin
          cfg_ff[8*gi +: 8] <= commit_data[8*gi +: 8];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wait_ack_o      <= 1'b1;
      wait_ack_oe_o   <= 1'b0;
      d_o             <= 16'h0000;
      d_oe_o          <= 2'h0;
      cfg_reg_o       <= `HP_CFG_RESET;
      write_pending_o <= 1'b0;
    end else begin
      wait_ack_oe_o   <= sel;
      wait_ack_o      <= ~(nxt_wait ^ cfg_ff[`HP_F_WAIT_POL]);
      d_oe_o          <= {sel & rd_act & bus16, sel & rd_act};
      if (state_ff == ST_BUSY && busy_done && is_read_ff) begin
        d_o <= rdata_map;
      end
      cfg_reg_o       <= cfg_ff;
      write_pending_o <= pend_ff;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  chk_oe_on_select: assert property (
    !sel |=> !wait_ack_oe_o) else $error("wait driven without chip select");
  chk_first_level: assert property (
    (state_ff == ST_IDLE && sel && posted && !rd_act && !wr_act)
    |=> wait_act_ff == $past(pend_ff)) else $error("wrong initial wait level");
  chk_posted_wait: assert property (
    (posted_cap && sel) |=> wait_act_ff && pend_ff) else $error("no wait after posted write");
  chk_posted_data: assert property (
    posted_cap |=> stage_data_ff == $past(wdata_map)) else $error("posted data not captured");
  chk_np_start: assert property (
    (state_ff == ST_IDLE && sel && !posted && !rd_act && !wr_act)
    |=> !wait_act_ff) else $error("non-posted start level wrong");
  chk_np_strobe: assert property (
    (sel && wr_act && !wr_q_ff && !posted && state_ff != ST_DONE)
    |=> wait_act_ff [*2]) else $error("non-posted strobe ignored");
  chk_np_commit: assert property (
    np_commit |=> ((cfg_ff ^ $past(wdata_map)) & $past(be_mask)) == 32'h0)
    else $error("non-posted update missing");
  chk_read_wait: assert property (
    (sel && rd_act && !rd_q_ff && state_ff != ST_DONE) |=> wait_act_ff)
    else $error("read strobe did not raise wait");
  chk_read_drive: assert property (
    (sel && rd_act) |=> d_oe_o[0]) else $error("read data not driven");
  chk_upper_idle: assert property (
    !bus16 |=> !d_oe_o[1]) else $error("upper lane driven in 8-bit mode");
  chk_pend_bound: assert property (
    $rose(pend_ff) |-> ##[1:PEND_MAX] (!pend_ff || posted_cap))
    else $error("pending write never completed");

endmodule

// *** rtl/host_port_params.svh ***
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

// ----------------------------------------
// Address decode
// ----------------------------------------
`define HP_CFG_SEL        2'h3

// ----------------------------------------
// Configuration register fields
// ----------------------------------------
`define HP_F_WAIT_POL     0
`define HP_F_CS_POL       1
`define HP_F_RD_POL       2
`define HP_F_WR_POL       3
`define HP_F_RW_MODE      4
`define HP_F_BUS16        5
`define HP_F_BIG_END      6
`define HP_F_POSTED       7
`define HP_CFG_RESET      32'h0000_00ae

// ----------------------------------------
// Timing
// ----------------------------------------
`define HP_CLK_NS         8
`define HP_RD_LAT_NS      40
`define HP_NP_LAT_NS      40
`define HP_CMT_NS         80
`define HP_RD_LAT_CYC     ((`HP_RD_LAT_NS + `HP_CLK_NS - 1) / `HP_CLK_NS)
`define HP_NP_LAT_CYC     ((`HP_NP_LAT_NS + `HP_CLK_NS - 1) / `HP_CLK_NS)
`define HP_CMT_CYC        ((`HP_CMT_NS + `HP_CLK_NS - 1) / `HP_CLK_NS)

`endif

// *** rtl/host_port_pkg.sv ***
package host_port_pkg;

  // Gray sequence along IDLE -> SEL -> BUSY -> DONE
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SEL  = 2'h1,
    ST_BUSY = 2'h3,
    ST_DONE = 2'h2
  } cyc_state_type;

endpackage

// *** rtl/strobe_decode.sv ***
`timescale 1ns/100ps
module strobe_decode (
  // Raw pins
  input  wire logic cs_i,
  input  wire logic rd_rw_i,
  input  wire logic wr_strobe_i,
  // Configuration
  input  wire logic cs_pol_i,
  input  wire logic rd_pol_i,
  input  wire logic wr_pol_i,
  input  wire logic rw_mode_i,
  // Decoded activity
  output logic      cs_act_o,
  output logic      rd_act_o,
  output logic      wr_act_o
);

  logic rd_lvl;
  logic wr_lvl;

  assign cs_act_o = ~(cs_i ^ cs_pol_i);
  assign rd_lvl   = ~(rd_rw_i ^ rd_pol_i);
  assign wr_lvl   = ~(wr_strobe_i ^ wr_pol_i);

  assign rd_act_o = rw_mode_i ? (wr_lvl & rd_lvl) : rd_lvl;
  assign wr_act_o = rw_mode_i ? (wr_lvl & ~rd_lvl) : wr_lvl;

endmodule

// *** tb/host_model.sv ***
`timescale 1ns/100ps
module host_model (
  // Clock
  input  wire logic        clk_sys_i,
  // Strobes and address
  output logic             cs_o,
  output logic             rd_o,
  output logic             wr_o,
  output logic      [3:0]  addr_o,
  // Data wire and wait
  output logic      [15:0] d_o,
  input  wire logic [15:0] dev_d_i,
  input  wire logic [1:0]  dev_oe_i,
  input  wire logic        wait_i,
  input  wire logic        wait_oe_i,
  // Direction plus transfer_strobe scheme
  input  wire logic        rw_mode_i
);
  logic [15:0] hd;
  logic        wact;

  // Released host lanes show the inverse of their last value
  assign d_o[7:0]  = dev_oe_i[0] ? dev_d_i[7:0] : hd[7:0];
  assign d_o[15:8] = dev_oe_i[1] ? dev_d_i[15:8] : hd[15:8];
  assign wact      = wait_oe_i & ~wait_i;

  initial begin
    cs_o = 1'b0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 4'h0;
    hd = 16'h5a5a;
  end

  // One bus cycle; fw is the wait level seen before the strobe
  task automatic access(input logic wr, input logic pst, input logic [3:0] a,
                        input logic [15:0] d, output logic fw, output logic ok,
                        output logic [15:0] q, output logic [1:0] oe);
    logic seen;
    int   n;
    seen = 1'b0;
    ok = 1'b0;
    q = 16'h0;
    oe = 2'h0;
    @(posedge clk_sys_i);
    cs_o <= 1'b1;
    addr_o <= a;
    repeat (2) @(posedge clk_sys_i);
    fw = wact;
    // data valid from strobe leading edge
    if (wr) begin
      wr_o <= 1'b1;
      hd <= d;
    end else begin
      rd_o <= 1'b1;
      // transfer_strobe qualifies a read in rw mode
      wr_o <= rw_mode_i;
    end
    if (pst) begin
      repeat (2) @(posedge clk_sys_i);
      wr_o <= 1'b0;
      for (n = 0; n < 4; n++) begin
        @(posedge clk_sys_i);
        if (wact) begin
          ok = 1'b1;
        end
      end
    end else begin
      for (n = 0; n < 64 && !ok; n++) begin
        @(posedge clk_sys_i);
        if (seen && !wact) begin
          ok = 1'b1;
          q = d_o;
          oe = dev_oe_i;
        end
        seen = seen | wact;
      end
      // strobe and data held until wait inactive
      rd_o <= 1'b0;
      wr_o <= 1'b0;
    end
    @(posedge clk_sys_i);
    cs_o <= 1'b0;
    hd <= ~hd;
    repeat (2) @(posedge clk_sys_i);
  endtask
endmodule

// *** tb/test_host_port_cfg_access.sv ***
`timescale 1ns/100ps
module test_host_port_cfg_access;
  logic        clk_sys_i, rst_n_i, cs, rd, wr, wait_ack, wait_oe, pend, fw, ok, rw_mode;
  logic [3:0]  addr;
  logic [15:0] d_wire, d_dev, q;
  logic [1:0]  d_oe, oe;
  logic [31:0] cfg;
  int          mismatches, checked;

  host_model host_model_inst (
    .clk_sys_i(clk_sys_i), .cs_o(cs), .rd_o(rd), .wr_o(wr), .addr_o(addr),
    .d_o(d_wire), .dev_d_i(d_dev), .dev_oe_i(d_oe), .wait_i(wait_ack),
    .wait_oe_i(wait_oe), .rw_mode_i(rw_mode));

  host_port_cfg_access host_port_cfg_access_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cs_i(cs), .rd_rw_i(rd),
    .wr_strobe_i(wr), .addr_i(addr), .d_i(d_wire), .d_o(d_dev), .d_oe_o(d_oe),
    .wait_ack_o(wait_ack), .wait_ack_oe_o(wait_oe), .cfg_reg_o(cfg),
    .write_pending_o(pend));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic t_reset();
    check(cfg, 32'h0000_00ae);
    check({pend, wait_oe, d_oe}, 32'h0);
  endtask

  task automatic t_posted();
    host_model_inst.access(1'b1, 1'b1, 4'he, 16'hbeef, fw, ok, q, oe);
    check(fw, 1'b0);
    check(ok, 1'b1);
    check(pend, 1'b1);
    repeat (12) @(posedge clk_sys_i);
    check({pend, wait_oe}, 2'b0);
    check(cfg, 32'hbeef_00ae);
  endtask

  // Read issued while the posted write still commits
  task automatic t_pending();
    host_model_inst.access(1'b1, 1'b1, 4'he, 16'h1234, fw, ok, q, oe);
    host_model_inst.access(1'b0, 1'b0, 4'he, 16'h0, fw, ok, q, oe);
    check(fw, 1'b1);
    check({ok, oe, q}, {1'b1, 2'b11, 16'h1234});
  endtask

  task automatic t_nonposted();
    host_model_inst.access(1'b1, 1'b1, 4'hc, 16'h002e, fw, ok, q, oe);
    repeat (12) @(posedge clk_sys_i);
    host_model_inst.access(1'b1, 1'b0, 4'he, 16'h5678, fw, ok, q, oe);
    check(fw, 1'b0);
    check(ok, 1'b1);
    check(cfg, 32'h5678_002e);
    check(pend, 1'b0);
  endtask

  task automatic t_endian();
    host_model_inst.access(1'b1, 1'b0, 4'hc, 16'h006e, fw, ok, q, oe);
    host_model_inst.access(1'b0, 1'b0, 4'hc, 16'h0, fw, ok, q, oe);
    check(q, 16'h6e00);
    host_model_inst.access(1'b0, 1'b0, 4'he, 16'h0, fw, ok, q, oe);
    check(q, 16'h7856);
  endtask

  task automatic t_byte();
    host_model_inst.access(1'b1, 1'b0, 4'hc, 16'h4e00, fw, ok, q, oe);
    host_model_inst.access(1'b1, 1'b0, 4'he, 16'hff99, fw, ok, q, oe);
    check(cfg, 32'h5699_004e);
    host_model_inst.access(1'b0, 1'b0, 4'hf, 16'h0, fw, ok, q, oe);
    check({oe, q[7:0]}, {2'b01, 8'h56});
  endtask

  // Direction on the read line, transfer_strobe on the write line
  task automatic t_rwmode();
    host_model_inst.access(1'b1, 1'b0, 4'hc, 16'h005e, fw, ok, q, oe);
    rw_mode <= 1'b1;
    host_model_inst.access(1'b1, 1'b0, 4'hd, 16'h0077, fw, ok, q, oe);
    check(cfg, 32'h5699_775e);
    host_model_inst.access(1'b0, 1'b0, 4'he, 16'h0, fw, ok, q, oe);
    check({ok, oe, q[7:0]}, {1'b1, 2'b01, 8'h99});
    check(cfg, 32'h5699_775e);
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    rst_n_i = 1'b0;
    mismatches = 0;
    checked = 0;
    rw_mode = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    t_reset();
    t_posted();
    t_pending();
    t_nonposted();
    t_endian();
    t_byte();
    t_rwmode();
    results();
  end

  // Whole run is a few hundred cycles; this only cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    mismatches++;
    results();
  end
endmodule
